/* File: verilog/adfpc_pkg.sv */
// package for the asynchronous dram fast page controller
package adfpc_pkg;

	localparam int CLK_PERIOD_NS = 10;

	// timing figures in ns, power-up in us, refresh in ms (slower grade)
	localparam int T_ROW_PRECHARGE_NS   = 70;
	localparam int T_ROW_PULSE_NS       = 100;
	localparam int T_ROW_TO_COLUMN_NS   = 25;
	localparam int T_ROW_ADDR_HOLD_NS   = 15;
	localparam int T_COL_PULSE_NS       = 25;
	localparam int T_COL_PRECHARGE_NS   = 10;
	localparam int T_ROW_ACCESS_NS      = 100;
	localparam int T_COL_ACCESS_NS      = 25;
	localparam int T_COLUMN_SETUP_NS    = 10;
	localparam int T_COLUMN_HOLD_NS     = 30;
	localparam int T_ROW_TO_STORE_NS    = 100;
	localparam int T_COL_TO_STORE_NS    = 25;
	localparam int T_STORE_PULSE_NS     = 20;
	localparam int T_TEST_SETUP_NS      = 10;
	localparam int T_POWERUP_US         = 200;
	localparam int T_REFRESH_MS         = 16;
	localparam int REFRESH_ROWS         = 1024;
	localparam int INIT_REFRESHES       = 8;

	function automatic int cyc_min(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int cyc_max(input int ns);
		int c;
		c = ns / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int C_ROW_PRECHARGE = cyc_min(T_ROW_PRECHARGE_NS);
	localparam int C_ROW_PULSE     = cyc_min(T_ROW_PULSE_NS);
	localparam int C_ROW_TO_COL    = cyc_min(T_ROW_TO_COLUMN_NS);
	localparam int C_ROW_HOLD      = cyc_min(T_ROW_ADDR_HOLD_NS);
	localparam int C_COL_PULSE     = cyc_min(T_COL_PULSE_NS);
	localparam int C_COL_PRECHARGE = cyc_min(T_COL_PRECHARGE_NS);
	localparam int C_ROW_ACCESS    = cyc_min(T_ROW_ACCESS_NS);
	localparam int C_COL_ACCESS    = cyc_min(T_COL_ACCESS_NS);
	localparam int C_COLUMN_SETUP  = cyc_min(T_COLUMN_SETUP_NS);
	localparam int C_COLUMN_HOLD   = cyc_min(T_COLUMN_HOLD_NS);
	localparam int C_ROW_TO_STORE  = cyc_min(T_ROW_TO_STORE_NS);
	localparam int C_COL_TO_STORE  = cyc_min(T_COL_TO_STORE_NS);
	localparam int C_STORE_PULSE   = cyc_min(T_STORE_PULSE_NS);
	localparam int C_TEST_SETUP    = cyc_min(T_TEST_SETUP_NS);
	localparam int C_POWERUP_DEF   = T_POWERUP_US * 1000 / CLK_PERIOD_NS;
	localparam int C_REF_INTERVAL_DEF = (T_REFRESH_MS * 1000000 / CLK_PERIOD_NS) / REFRESH_ROWS;

	localparam int ADDR_W  = 11;
	localparam int CELL_W  = 22;
	localparam int PAGE_COLS = 2048;
	localparam int TIMER_W = 16;

	typedef enum logic [2:0] {
		ADFPC_OP_READ,
		ADFPC_OP_WRITE,
		ADFPC_OP_RMW,
		ADFPC_OP_TEST_IN,
		ADFPC_OP_TEST_OUT
	} adfpc_op_t;

	typedef struct packed {
		adfpc_op_t          op;
		logic [CELL_W-1:0]  addr;
		logic               wdata;
		logic               page_keep;
	} adfpc_req_t;

	typedef struct packed {
		logic               row_strobe_n;
		logic               col_strobe_n;
		logic               store_n;
		logic [ADDR_W-1:0]  addr;
		logic               input_bit;
	} adfpc_pins_t;

endpackage : adfpc_pkg

/* File: verilog/adfpc_timer.sv */
// down counter used for the strobe delays except the row strobe low time
`timescale 1ns/1ps
`default_nettype none
module adfpc_timer (
	input  wire logic                           mclk_i,  // clock
	input  wire logic                           rst_b_i, // async reset
	input  wire logic                           load_i,  // load count
	input  wire logic [adfpc_pkg::TIMER_W-1:0]  value_i, // cycles to wait
	output logic                                done_o   // count exhausted
);
	import adfpc_pkg::*;

	logic [TIMER_W-1:0] cnt_r;
	logic [TIMER_W-1:0] cnt_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		if (load_i) begin
			cnt_nxt = value_i;
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// no load term: callers load on done, which would loop
	assign done_o = (cnt_r == '0);
endmodule // adfpc_timer
`default_nettype wire

/* File: verilog/adfpc_ctrl.sv */
// controller that drives a 4M x 1 asynchronous dram over its strobes
`timescale 1ns/1ps
`default_nettype none
module adfpc_ctrl #(
	parameter int POWERUP_CYC = adfpc_pkg::C_POWERUP_DEF,     // power-up pause
	parameter int REF_INTERVAL = adfpc_pkg::C_REF_INTERVAL_DEF // refresh spacing
) (
	input  wire logic                 mclk_i,      // clock
	input  wire logic                 rst_b_i,     // async reset
	input  wire adfpc_pkg::adfpc_req_t req_i,      // request
	input  wire logic                 req_valid_i, // request valid
	output logic                      req_ready_o, // request taken
	output logic                      rsp_valid_o, // read data pulse
	output logic                      rsp_data_o,  // read data
	output logic                      init_done_o, // init finished
	output logic                      test_mode_o, // device in test mode
	output adfpc_pkg::adfpc_pins_t    pins_o,      // strobes, address, data
	input  wire logic                 output_bit_i // device data out
);
	import adfpc_pkg::*;

	typedef enum logic [3:0] {
		S_POWERUP, S_IDLE, S_ROW, S_COL_SETUP, S_COL, S_STORE, S_COL_END,
		S_PAGE_WAIT, S_ROW_END, S_PRECHARGE, S_CBR_SETUP, S_CBR_ROW, S_CBR_END
	} adfpc_state_t;

	adfpc_state_t      st_r, st_nxt;
	adfpc_pins_t       pin_r, pin_nxt;
	adfpc_req_t        cur_r, cur_nxt;
	logic              rsp_v_r, rsp_v_nxt;
	logic              rsp_d_r, rsp_d_nxt;
	logic [3:0]        init_cnt_r, init_cnt_nxt;
	logic              test_r, test_nxt;
	logic              cbr_test_r, cbr_test_nxt;
	logic [TIMER_W-1:0] row_age_r, row_age_nxt;
	logic [31:0]       ref_cnt_r, ref_cnt_nxt;
	logic              ref_due_r, ref_due_nxt;
	logic              tload;
	logic [TIMER_W-1:0] tval;
	logic              tdone;
	logic              pu_seen_r;

	adfpc_timer u_timer (
		.mclk_i  (mclk_i),
		.rst_b_i (rst_b_i),
		.load_i  (tload),
		.value_i (tval),
		.done_o  (tdone)
	);

	function automatic logic [TIMER_W-1:0] tc(input int c);
		return TIMER_W'(c);
	endfunction

	function automatic logic is_read(input adfpc_op_t op);
		return (op == ADFPC_OP_READ) || (op == ADFPC_OP_TEST_OUT);
	endfunction

	always_comb begin
		ref_cnt_nxt = ref_cnt_r + 32'h0000_0001;
		ref_due_nxt = ref_due_r;
		if (ref_cnt_r >= 32'(REF_INTERVAL - 1)) begin
			ref_cnt_nxt = '0;
			ref_due_nxt = 1'b1;
		end
		// set wins over clear
		if (st_r == S_CBR_END && tdone && !(ref_cnt_r >= 32'(REF_INTERVAL - 1))) begin
			ref_due_nxt = 1'b0;
		end
	end

	always_comb begin
		st_nxt       = st_r;
		pin_nxt      = pin_r;
		cur_nxt      = cur_r;
		rsp_v_nxt    = 1'b0;
		rsp_d_nxt    = rsp_d_r;
		init_cnt_nxt = init_cnt_r;
		test_nxt     = test_r;
		cbr_test_nxt = cbr_test_r;
		row_age_nxt  = (row_age_r == '1) ? row_age_r : row_age_r + 1'b1;
		tload        = 1'b0;
		tval         = '0;
		req_ready_o  = 1'b0;
		unique case (st_r)
			S_POWERUP: if (!pu_seen_r) begin
				tload = 1'b1;
				tval  = tc(POWERUP_CYC);
			end else if (tdone) begin
				st_nxt = S_PRECHARGE;
				tload  = 1'b1;
				tval   = tc(C_ROW_PRECHARGE);
			end
			S_IDLE: begin
				if (ref_due_r || init_cnt_r != 4'(INIT_REFRESHES)) begin
					pin_nxt.col_strobe_n = 1'b0;
					pin_nxt.store_n      = 1'b1;
					cbr_test_nxt         = 1'b0;
					st_nxt = S_CBR_SETUP;
					tload  = 1'b1;
					tval   = tc(C_COLUMN_SETUP);
				end else if (req_valid_i) begin
					req_ready_o = 1'b1;
					cur_nxt     = req_i;
					if (req_i.op == ADFPC_OP_TEST_IN) begin
						pin_nxt.col_strobe_n = 1'b0;
						pin_nxt.store_n      = 1'b0;
						cbr_test_nxt         = 1'b1;
						st_nxt = S_CBR_SETUP;
						tload  = 1'b1;
						tval   = tc(C_COLUMN_SETUP > C_TEST_SETUP ? C_COLUMN_SETUP : C_TEST_SETUP);
					end else begin
						pin_nxt.addr         = req_i.addr[CELL_W-1:ADDR_W];
						pin_nxt.row_strobe_n = 1'b0;
						row_age_nxt = '0;
						st_nxt = S_ROW;
						tload  = 1'b1;
						tval   = tc(C_ROW_TO_COL > C_ROW_HOLD ? C_ROW_TO_COL : C_ROW_HOLD);
					end
				end
			end
			S_ROW: if (tdone) begin
				pin_nxt.addr = cur_r.addr[ADDR_W-1:0];
				pin_nxt.store_n = !(cur_r.op == ADFPC_OP_WRITE);
				pin_nxt.input_bit = cur_r.wdata;
				st_nxt = S_COL_SETUP;
			end
			S_COL_SETUP: begin
				pin_nxt.col_strobe_n = 1'b0;
				st_nxt = S_COL;
				tload  = 1'b1;
				tval = tc(C_COL_ACCESS > (C_ROW_ACCESS - int'(row_age_r)) ?
					C_COL_ACCESS : C_ROW_ACCESS - int'(row_age_r));
			end
			S_COL: if (tdone) begin
				if (is_read(cur_r.op) || cur_r.op == ADFPC_OP_RMW) begin
					rsp_v_nxt = is_read(cur_r.op) || cur_r.op == ADFPC_OP_RMW;
					rsp_d_nxt = output_bit_i;
				end
				if (cur_r.op == ADFPC_OP_RMW) begin
					pin_nxt.store_n = 1'b0;
					st_nxt = S_STORE;
					tload  = 1'b1;
					tval   = tc(C_STORE_PULSE);
				end else begin
					st_nxt = S_COL_END;
				end
			end
			S_STORE: if (tdone) begin
				pin_nxt.store_n = 1'b1;
				st_nxt = S_COL_END;
			end
			S_COL_END: begin
				pin_nxt.col_strobe_n = 1'b1;
				pin_nxt.store_n      = 1'b1;
				st_nxt = S_PAGE_WAIT;
				tload  = 1'b1;
				tval   = tc(C_COL_PRECHARGE);
			end
			S_PAGE_WAIT: if (tdone) begin
				if (cur_r.page_keep && req_valid_i && req_i.op != ADFPC_OP_TEST_IN &&
					req_i.addr[CELL_W-1:ADDR_W] == cur_r.addr[CELL_W-1:ADDR_W] && !ref_due_r) begin
					req_ready_o = 1'b1;
					cur_nxt     = req_i;
					pin_nxt.addr      = req_i.addr[ADDR_W-1:0];
					pin_nxt.store_n   = !(req_i.op == ADFPC_OP_WRITE);
					pin_nxt.input_bit = req_i.wdata;
					st_nxt = S_COL_SETUP;
				end else begin
					st_nxt = S_ROW_END;
				end
			end
			S_ROW_END: begin
				if (row_age_r >= tc(C_ROW_PULSE)) begin
					pin_nxt.row_strobe_n = 1'b1;
					st_nxt = S_PRECHARGE;
					tload  = 1'b1;
					tval   = tc(C_ROW_PRECHARGE);
				end
			end
			S_PRECHARGE: if (tdone) begin
				st_nxt = S_IDLE;
			end
			S_CBR_SETUP: if (tdone) begin
				pin_nxt.row_strobe_n = 1'b0;
				row_age_nxt = '0;
				st_nxt = S_CBR_ROW;
				tload  = 1'b1;
				tval   = tc(C_COLUMN_HOLD);
			end
			S_CBR_ROW: begin
				if (tdone) begin
					pin_nxt.col_strobe_n = 1'b1;
					pin_nxt.store_n      = 1'b1;
				end
				if (tdone || pin_r.col_strobe_n) begin
					st_nxt = S_CBR_END;
				end
			end
			S_CBR_END: begin
				if (row_age_r >= tc(C_ROW_PULSE)) begin
					pin_nxt.row_strobe_n = 1'b1;
					test_nxt = cbr_test_r;
					if (init_cnt_r != 4'(INIT_REFRESHES) && !cbr_test_r) begin
						init_cnt_nxt = init_cnt_r + 4'h1;
					end
					st_nxt = S_PRECHARGE;
					tload  = 1'b1;
					tval   = tc(C_ROW_PRECHARGE);
				end
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r       <= S_POWERUP;
			pin_r      <= '{row_strobe_n: 1'b1, col_strobe_n: 1'b1, store_n: 1'b1, addr: '0, input_bit: 1'b0};
			cur_r      <= '0;
			rsp_v_r    <= 1'b0;
			rsp_d_r    <= 1'b0;
			init_cnt_r <= 4'h0;
			test_r     <= 1'b0;
			cbr_test_r <= 1'b0;
			row_age_r  <= '0;
			ref_cnt_r  <= '0;
			ref_due_r  <= 1'b0;
		end else begin
			st_r       <= st_nxt;
			pin_r      <= pin_nxt;
			cur_r      <= cur_nxt;
			rsp_v_r    <= rsp_v_nxt;
			rsp_d_r    <= rsp_d_nxt;
			init_cnt_r <= init_cnt_nxt;
			test_r     <= test_nxt;
			cbr_test_r <= cbr_test_nxt;
			row_age_r  <= row_age_nxt;
			ref_cnt_r  <= ref_cnt_nxt;
			ref_due_r  <= ref_due_nxt;
		end
	end

	// power-up timer load on first cycle after reset
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pu_seen_r <= 1'b0;
		end else begin
			pu_seen_r <= 1'b1;
		end
	end

	assign pins_o      = pin_r;
	assign rsp_valid_o = rsp_v_r;
	assign rsp_data_o  = rsp_d_r;
	assign init_done_o = (init_cnt_r == 4'(INIT_REFRESHES));
	assign test_mode_o = test_r;
endmodule // adfpc_ctrl
`default_nettype wire

/* File: test/adfpc_ctrl_assertions.sv */
// assertions on the dram controller pins
`timescale 1ns/1ps
`default_nettype none
module adfpc_ctrl_chk (
	input wire logic                   mclk_i,      // clock
	input wire logic                   rst_b_i,     // reset
	input wire adfpc_pkg::adfpc_req_t  req_i,       // request
	input wire logic                   req_valid_i, // valid
	input wire logic                   req_ready_o, // taken
	input wire logic                   rsp_valid_o, // sample
	input wire logic                   init_done_o, // init done
	input wire adfpc_pkg::adfpc_pins_t pins_o       // pins
);
	import adfpc_pkg::*;
	logic [21:0] req_r;
	logic [21:0] req_nxt;
	logic        wd_r;
	logic        wd_nxt;
	logic [7:0]  low_cnt_r;
	logic [7:0]  low_cnt_nxt;
	always_comb begin
		req_nxt = (req_valid_i && req_ready_o) ? req_i.addr : req_r;
		wd_nxt  = (req_valid_i && req_ready_o) ? req_i.wdata : wd_r;
		// cycles the row strobe has been low, saturating
		low_cnt_nxt = pins_o.row_strobe_n ? 8'h00 : ((low_cnt_r == 8'hFF) ? low_cnt_r : low_cnt_r + 8'h01);
	end
	always_ff @(posedge mclk_i or negedge rst_b_i)
		if (!rst_b_i) begin
			req_r <= '0;
			wd_r  <= '0;
			low_cnt_r <= 8'h00;
		end else begin
			req_r <= req_nxt;
			wd_r  <= wd_nxt;
			low_cnt_r <= low_cnt_nxt;
		end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	chk_row_addr: assert property (
		$fell(pins_o.row_strobe_n) && pins_o.col_strobe_n |-> pins_o.addr == req_r[21:11])
		else $error("row address wrong");
	chk_col_addr: assert property (
		$fell(pins_o.col_strobe_n) && !pins_o.row_strobe_n
		|-> pins_o.addr == req_r[10:0] && $past(pins_o.row_strobe_n, 2) == 1'h0)
		else $error("column address wrong");
	chk_row_pulse: assert property ($fell(pins_o.row_strobe_n) |-> !pins_o.row_strobe_n [*8])
		else $error("row strobe pulse short");
	chk_row_width: assert property ($rose(pins_o.row_strobe_n) |-> low_cnt_r >= 8'(C_ROW_PULSE))
		else $error("row strobe low time below minimum");
	chk_col_pulse: assert property ($fell(pins_o.col_strobe_n) |-> !pins_o.col_strobe_n [*3])
		else $error("column strobe pulse short");
	chk_row_precharge: assert property ($rose(pins_o.row_strobe_n) |-> pins_o.row_strobe_n [*7])
		else $error("row precharge short");
	chk_data_valid: assert property (
		($fell(pins_o.store_n) || $fell(pins_o.col_strobe_n)) && !pins_o.store_n
		&& !pins_o.col_strobe_n && !pins_o.row_strobe_n |-> pins_o.input_bit == wd_r)
		else $error("write data not valid");
	chk_init_gate: assert property (!init_done_o |-> !req_ready_o)
		else $error("request taken before init");
	chk_refresh_setup: assert property (
		$fell(pins_o.row_strobe_n) && !pins_o.col_strobe_n |-> $past(pins_o.col_strobe_n) == 1'h0)
		else $error("column first setup short");
	cov_read: cover property (rsp_valid_o);
	cov_early_write: cover property ($fell(pins_o.col_strobe_n) && !pins_o.store_n && !pins_o.row_strobe_n);
	cov_page: cover property ($fell(pins_o.col_strobe_n) && $past(pins_o.row_strobe_n, 8) == 1'h0);
endmodule // adfpc_ctrl_chk
bind adfpc_ctrl adfpc_ctrl_chk i_adfpc_ctrl_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .req_i(req_i),
	.req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
	.init_done_o(init_done_o), .pins_o(pins_o));
`default_nettype wire

/* File: test/adfpc_dram_model.sv */
// behavioural 4M x 1 dram for the bench
`timescale 1ns/1ps
`default_nettype none
module adfpc_dram_model (
	input  wire adfpc_pkg::adfpc_pins_t pins_i,      // strobes, address, data
	output logic                        output_bit_o // data out
);
	import adfpc_pkg::*;
	bit          mem[bit [21:0]];
	logic [10:0] row_r;
	logic [21:0] cell_r;
	bit   [9:0]  ref_cnt_r;
	bit          test_r;
	bit          act_r;
	realtime     row_t;
	function automatic bit get(input logic [21:0] a);
		return mem.exists(a) ? mem[a] : 1'h0;
	endfunction
	function automatic logic [21:0] sa(input logic [21:0] a, input int k);
		return test_r ? {k[2], a[20:11], k[1], a[9:1], k[0]} : a;
	endfunction
	task automatic wr();
		for (int k = 0; k < 8; k++)
			mem[sa(cell_r, k)] = pins_i.input_bit;
	endtask
	function automatic bit rd();
		int n;
		n = 0;
		for (int k = 0; k < 8; k++)
			n += get(sa(cell_r, k));
		return test_r ? (n == 0 || n == 8) : get(cell_r);
	endfunction
	initial output_bit_o = 1'h0;
	always @(negedge pins_i.row_strobe_n) begin
		row_t = $realtime;
		if (!pins_i.col_strobe_n) begin
			test_r    = !pins_i.store_n;
			ref_cnt_r = ref_cnt_r + 10'h1;
		end else begin
			row_r = pins_i.addr;
			act_r = 1'h1;
		end
	end
	always @(posedge pins_i.row_strobe_n)
		act_r = 1'h0;
	always @(negedge pins_i.col_strobe_n) if (act_r && !pins_i.row_strobe_n) begin
		cell_r = {row_r, pins_i.addr};
		if (!pins_i.store_n)
			wr();
		else begin
			output_bit_o = ~output_bit_o;
			#(T_COL_ACCESS_NS);
			if (row_t + T_ROW_ACCESS_NS > $realtime)
				#(row_t + T_ROW_ACCESS_NS - $realtime);
			if (!pins_i.col_strobe_n)
				output_bit_o = rd();
		end
	end
	always @(negedge pins_i.store_n)
		if (act_r && !pins_i.col_strobe_n)
			wr();
	always @(posedge pins_i.col_strobe_n)
		output_bit_o = ~output_bit_o;
endmodule // adfpc_dram_model
`default_nettype wire

/* File: test/tb_adfpc_ctrl.sv */
// self-checking bench for the dram controller
`timescale 1ns/1ps
`default_nettype none
module tb_adfpc_ctrl;
	import adfpc_pkg::*;
	logic        mclk_i;
	logic        rst_b_i;
	adfpc_req_t  req_i;
	logic        req_valid_i;
	logic        req_ready_o;
	logic        rsp_valid_o;
	logic        rsp_data_o;
	logic        init_done_o;
	logic        test_mode_o;
	adfpc_pins_t pins;
	logic        out_bit;
	int          err_total;
	int          checks_done;
	bit          exp_q[$];
	logic [21:0] ad[8];
	logic        dv[8];
	adfpc_ctrl #(.POWERUP_CYC(20), .REF_INTERVAL(2000)) i_adfpc_ctrl (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
		.req_i(req_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
		.rsp_data_o(rsp_data_o), .init_done_o(init_done_o), .test_mode_o(test_mode_o), .pins_o(pins),
		.output_bit_i(out_bit));
	adfpc_dram_model i_adfpc_dram_model (.pins_i(pins), .output_bit_o(out_bit));
	initial begin
		mclk_i = 1'h0;
		forever #5 mclk_i = ~mclk_i;
	end
	task automatic cmp(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// reads note d as expected, rmw notes its inverse
	task automatic go(input adfpc_op_t o, input logic [21:0] a, input logic d, input logic k);
		int n;
		if (o == ADFPC_OP_READ || o == ADFPC_OP_TEST_OUT || o == ADFPC_OP_RMW)
			exp_q.push_back(o == ADFPC_OP_RMW ? !d : d);
		req_i       = '{op: o, addr: a, wdata: d, page_keep: k};
		req_valid_i = 1'h1;
		n = 0;
		do begin
			@(negedge mclk_i);
			n++;
		end while (req_ready_o !== 1'h1 && n < 4000);
		if (n == 4000)
			err_total++;
		@(posedge mclk_i);
		#1;
	endtask
	task automatic wait_tm(input logic v, input int lim);
		req_valid_i = 1'h0;
		for (int n = 0; n < lim && test_mode_o !== v; n++)
			@(negedge mclk_i);
		cmp(test_mode_o, v);
		@(posedge mclk_i);
		#1;
	endtask
	always @(negedge mclk_i)
		if (rsp_valid_o === 1'h1)
			cmp(rsp_data_o, exp_q.size() ? exp_q.pop_front() : 1'hx);
	initial begin
		#400000;
		err_total++;
		report_and_stop();
	end
	initial begin
		req_i       = '0;
		req_valid_i = 1'h0;
		rst_b_i     = 1'h0;
		repeat (8) @(posedge mclk_i);
		#1;
		rst_b_i = 1'h1;
		void'($urandom(32'h9DC74C12));
		repeat (20) @(negedge mclk_i);
		cmp(pins.row_strobe_n & pins.col_strobe_n, 1'h1);
		for (int n = 0; n < 3000 && init_done_o !== 1'h1; n++)
			@(negedge mclk_i);
		cmp(init_done_o, 1'h1);
		$display("test init done");
		@(posedge mclk_i);
		#1;
		go(ADFPC_OP_WRITE, 22'h0AAAAA, 1'h1, 1'h0);
		go(ADFPC_OP_TEST_IN, 22'h0, 1'h0, 1'h0);
		wait_tm(1'h1, 100);
		go(ADFPC_OP_TEST_OUT, 22'h0AAAAA, 1'h0, 1'h0);
		go(ADFPC_OP_WRITE, 22'h0AAAAA, 1'h0, 1'h0);
		go(ADFPC_OP_TEST_OUT, 22'h0AAAAA, 1'h1, 1'h0);
		go(ADFPC_OP_WRITE, 22'h0AAAAA, 1'h1, 1'h0);
		go(ADFPC_OP_TEST_OUT, 22'h0AAAAA, 1'h1, 1'h0);
		wait_tm(1'h0, 2200);
		go(ADFPC_OP_READ, 22'h2AAEAB, 1'h1, 1'h0);
		$display("test test_mode done");
		for (int i = 0; i < 8; i++) begin
			ad[i] = 22'($urandom);
			dv[i] = 1'($urandom);
			go(ADFPC_OP_WRITE, ad[i], dv[i], 1'h0);
		end
		for (int i = 7; i >= 0; i--)
			go(ADFPC_OP_READ, ad[i], dv[i], 1'h0);
		go(ADFPC_OP_RMW, ad[3], !dv[3], 1'h0);
		go(ADFPC_OP_READ, ad[3], !dv[3], 1'h0);
		$display("test random done");
		go(ADFPC_OP_WRITE, {ad[0][21:11], 11'h000}, 1'h1, 1'h1);
		go(ADFPC_OP_WRITE, {ad[0][21:11], 11'h7FF}, 1'h0, 1'h1);
		go(ADFPC_OP_READ, {ad[0][21:11], 11'h000}, 1'h1, 1'h1);
		go(ADFPC_OP_RMW, {ad[0][21:11], 11'h7FF}, 1'h1, 1'h1);
		go(ADFPC_OP_READ, {ad[0][21:11], 11'h7FF}, 1'h1, 1'h0);
		req_valid_i = 1'h0;
		repeat (40) @(posedge mclk_i);
		cmp(exp_q.size() == 0, 1'h1);
		$display("test page done");
		report_and_stop();
	end
endmodule // tb_adfpc_ctrl
`default_nettype wire
